// *** common/timer_if.sv ***
/*
 Load and busy handshake between the controller and its wait timer.
 Assumes both ends share one clock.
*/
`default_nettype none
interface timer_if #(parameter int W = 8);
  logic load;
  logic [W-1:0] count;
  logic busy;
  modport ctrl (output load, output count, input busy);
  modport timer (input load, input count, output busy);
endinterface
`default_nettype wire

// *** common/vref_train_pkg.sv ***
/*
 Constants, register map and command codes for the data-input reference
 training controller. Assumes a 100 MHz controller clock.
*/
`default_nettype none
package vref_train_pkg;
  // Clock and documented wait times.
  localparam int CLK_PERIOD_NS = 10;
  localparam int ENTRY_DELAY_NS = 150;
  localparam int EXIT_DELAY_NS = 150;
  localparam int SETTLE_SHORT_NS = 60;
  localparam int SETTLE_LONG_NS = 150;
  localparam int TIMER_W = 8;
  // Least waits round up to whole cycles.
  localparam logic [TIMER_W-1:0] ENTRY_CYC =
    TIMER_W'((ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] EXIT_CYC =
    TIMER_W'((EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] SETTLE_SHORT_CYC =
    TIMER_W'((SETTLE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] SETTLE_LONG_CYC =
    TIMER_W'((SETTLE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Software port.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CFG = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_USER = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hC;
  localparam logic [DATA_W-1:0] RDATA_NONE = 32'h0000_0000;

  // Control register fields.
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 2;
  localparam int CTRL_RANGE_BIT = 2;
  localparam int CTRL_CODE_LSB = 8;
  localparam int CODE_W = 6;
  localparam logic [CTRL_OP_W-1:0] OP_ENTER = 2'h1;
  localparam logic [CTRL_OP_W-1:0] OP_LEVEL = 2'h2;
  localparam logic [CTRL_OP_W-1:0] OP_EXIT = 2'h3;
  localparam logic [CODE_W-1:0] CODE_MAX = 6'h32;
  localparam logic [CODE_W-1:0] CODE_ZERO = 6'h00;
  localparam logic [CODE_W-1:0] CODE_ONE_STEP = 6'h01;

  // Configuration register fields.
  localparam int CFG_PDA_BIT = 0;
  localparam int CFG_SKIP_BIT = 1;

  // User command register field.
  localparam int USER_CMD_LSB = 0;
  localparam int USER_CMD_W = 3;

  // Status register fields.
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_LEVEL_OK_BIT = 2;
  localparam int ST_ERROR_BIT = 3;
  localparam int ST_RANGE_BIT = 4;
  localparam int ST_CODE_LSB = 8;

  // Training mode register address bits.
  localparam int MR_W = 8;
  localparam int MR_ENABLE_BIT = 7;
  localparam int MR_RANGE_BIT = 6;

  typedef enum logic [USER_CMD_W-1:0] {
    CMD_DES, CMD_ACT, CMD_WR, CMD_WRA, CMD_RD, CMD_RDA, CMD_PRE, CMD_MRS
  } cmd_t;
endpackage
`default_nettype wire

// *** rtl/sync2.sv ***
/*
 Two flip-flop synchroniser for a group of level inputs.
 Assumes the inputs are slow levels from outside the clock domain.
*/
`default_nettype none
module sync2 #(parameter int W = 2) (
  input wire logic clk_i,          // Destination clock.
  input wire logic rst_i,          // Synchronous reset, active high.
  input wire logic [W-1:0] d_i,    // Asynchronous levels.
  output logic [W-1:0] q_o         // Synchronised levels.
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule
`default_nettype wire

// *** rtl/vref_train_ctrl.sv ***
/*
 Controller that drives the memory's data-input reference training mode:
 entry, level steps, exit, and the commands allowed in between.
 Assumes software on a simple strobe port, and status pins from outside.
*/
// Our own choices: the address map and the strobed register port.
// Contract
// R1 - Level undefined until programmed by training.
// R2 - Bit 7 enables training mode.
// R3 - Bit 6 selects the reference range.
// R4 - Six-bit level code, codes above 50 reserved.
// R5 - Range and level written with enable.
// R6 - Entry write: bit 7 set, range chosen.
// R7 - Wait entry delay before training commands.
// R8 - Only ACT, WR, RD, PRE, DES, MRS allowed; the code also passes WRA and RDA.
// R9 - Dummy writes allowed before first level.
// R10 - Level write keeps enable and entry range.
// R11 - Write with bit 7 clear exits.
// R12 - Wait settling time after each level.
// R13 - Settle 60 ns single step, else 150.
// R14 - With per-device addressing only mode writes.
// R15 - Per-device addressing: data bit zero qualifies.
// R16 - Last level before exit stays in use.
// R17 - Exit only while all banks idle.
// R18 - Only deselects during exit delay.
// R19 - No level change in exit write.
// R20 - Settle fully before exiting.
// R21 - Range chosen at entry only.
// R22 - Training only after initialization completes.
// R23 - Device tracks a training-active flag.
`default_nettype none
module vref_train_ctrl (
  input wire logic MCLK_I,                // Controller clock.
  input wire logic RESET_I,               // Synchronous reset.
  input wire logic [3:0] ADDR_I,          // Register byte address.
  input wire logic [31:0] WDATA_I,        // Write data.
  input wire logic WR_I,                  // Write strobe.
  input wire logic RD_I,                  // Read strobe.
  output logic [31:0] RDATA_O,            // Read data, cycle after.
  input wire logic INIT_DONE_I,           // Memory initialised.
  input wire logic BANKS_IDLE_I,          // All banks idle.
  output logic [2:0] CMD_O,               // Command to the memory.
  output logic [7:0] MR_ADDR_O,           // Mode register address bits.
  output logic DQ0_O,                     // Data bit zero level.
  output logic DQ0_OE_O                   // Data bit zero drive enable.
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ENTRY_WAIT, ST_ACTIVE, ST_SETTLE, ST_EXIT_PEND,
    ST_EXIT_WAIT
  } state_t;

  localparam int TW = vref_train_pkg::TIMER_W;
  localparam int CW = vref_train_pkg::CODE_W;

  timer_if #(.W(TW)) tmr ();

  wait_timer #(.W(TW)) u_timer (
    .clk_i (MCLK_I),
    .rst_i (RESET_I),
    .tmr (tmr)
  );

  logic [1:0] pins_sync;
  logic init_ok;
  logic banks_idle;

  sync2 #(.W(2)) u_sync (
    .clk_i (MCLK_I),
    .rst_i (RESET_I),
    .d_i ({BANKS_IDLE_I, INIT_DONE_I}),
    .q_o (pins_sync)
  );

  assign init_ok = pins_sync[0];
  assign banks_idle = pins_sync[1];

  state_t state_r, state_nxt;
  logic range_r, range_nxt;
  logic [CW-1:0] code_r, code_nxt;
  logic level_ok_r, level_ok_nxt;
  logic first_level_r, first_level_nxt;
  logic err_r, err_nxt;
  logic pda_r, pda_nxt;
  logic skip_r, skip_nxt;
  vref_train_pkg::cmd_t cmd_r, cmd_nxt;
  logic [7:0] mr_r, mr_nxt;
  logic dq0_r, dq0_nxt;
  logic dq0_oe_r, dq0_oe_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic wr_ctrl, wr_cfg, wr_user, wr_status;
  logic [vref_train_pkg::CTRL_OP_W-1:0] op;
  logic [CW-1:0] new_code;
  logic [CW-1:0] step;
  logic new_range;
  logic refused;
  logic do_exit;
  vref_train_pkg::cmd_t user_cmd;

  assign wr_ctrl = WR_I && (ADDR_I == vref_train_pkg::OFS_CTRL);
  assign wr_cfg = WR_I && (ADDR_I == vref_train_pkg::OFS_CFG);
  assign wr_user = WR_I && (ADDR_I == vref_train_pkg::OFS_USER);
  assign wr_status = WR_I && (ADDR_I == vref_train_pkg::OFS_STATUS);
  assign op = WDATA_I[vref_train_pkg::CTRL_OP_LSB +:
                      vref_train_pkg::CTRL_OP_W];
  assign new_code = WDATA_I[vref_train_pkg::CTRL_CODE_LSB +: CW];
  assign new_range = WDATA_I[vref_train_pkg::CTRL_RANGE_BIT];
  assign user_cmd = vref_train_pkg::cmd_t'(
    WDATA_I[vref_train_pkg::USER_CMD_LSB +: vref_train_pkg::USER_CMD_W]);
  assign step = (new_code > code_r) ? (new_code - code_r)
                                    : (code_r - new_code);

  // Sequencer: one command per cycle, deselect when idle.
  always_comb begin
    state_nxt = state_r;
    range_nxt = range_r;
    code_nxt = code_r;
    level_ok_nxt = level_ok_r;
    first_level_nxt = first_level_r;
    cmd_nxt = vref_train_pkg::CMD_DES;
    mr_nxt = mr_r;
    tmr.load = 1'b0;
    tmr.count = '0;
    refused = 1'b0;
    do_exit = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (wr_ctrl && op == vref_train_pkg::OP_ENTER) begin
          if (init_ok) begin // R22
            // Entry write: code bits are don't-care, sent as zero.
            cmd_nxt = vref_train_pkg::CMD_MRS; // R6
            mr_nxt = {1'b1, new_range, vref_train_pkg::CODE_ZERO}; // R2 R3
            range_nxt = new_range; // R21
            first_level_nxt = 1'b1; // R9
            tmr.load = 1'b1;
            tmr.count = vref_train_pkg::ENTRY_CYC; // R7
            state_nxt = ST_ENTRY_WAIT; // R23
          end else begin
            refused = 1'b1;
          end
        end else if (wr_ctrl || wr_user) begin
          refused = 1'b1;
        end
      end
      ST_ENTRY_WAIT: begin
        refused = wr_ctrl || wr_user; // R7
        if (!tmr.busy) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (wr_ctrl && op == vref_train_pkg::OP_LEVEL) begin
          if (new_code > vref_train_pkg::CODE_MAX) begin
            refused = 1'b1; // R4
          end else begin
            cmd_nxt = vref_train_pkg::CMD_MRS;
            mr_nxt = {1'b1, range_r, new_code}; // R10 R21 R5
            code_nxt = new_code;
            level_ok_nxt = 1'b0; // R12
            first_level_nxt = 1'b0;
            tmr.load = 1'b1;
            if (!first_level_r && step == vref_train_pkg::CODE_ONE_STEP)
            begin
              tmr.count = vref_train_pkg::SETTLE_SHORT_CYC; // R13
            end else begin
              tmr.count = vref_train_pkg::SETTLE_LONG_CYC; // R13
            end
            state_nxt = ST_SETTLE;
          end
        end else if (wr_ctrl && op == vref_train_pkg::OP_EXIT) begin
          if (banks_idle) begin
            do_exit = 1'b1; // R17
          end else begin
            state_nxt = ST_EXIT_PEND;
          end
        end else if (wr_ctrl) begin
          refused = 1'b1;
        end else if (wr_user) begin
          if (pda_r || user_cmd == vref_train_pkg::CMD_MRS) begin
            refused = 1'b1; // R14 R8
          end else begin
            cmd_nxt = user_cmd; // R8 R9
          end
        end
      end
      ST_SETTLE: begin
        refused = wr_ctrl || wr_user; // R12 R20
        if (!tmr.busy) begin
          level_ok_nxt = 1'b1; // R1
          state_nxt = ST_ACTIVE;
        end
      end
      ST_EXIT_PEND: begin
        refused = wr_ctrl || wr_user;
        if (banks_idle) begin
          do_exit = 1'b1; // R17
        end
      end
      ST_EXIT_WAIT: begin
        refused = wr_ctrl || wr_user; // R18
        if (!tmr.busy) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (do_exit) begin
      // Exit write repeats the stored range and code unchanged.
      cmd_nxt = vref_train_pkg::CMD_MRS; // R11
      mr_nxt = {1'b0, range_r, code_r}; // R19 R16
      tmr.load = 1'b1;
      tmr.count = vref_train_pkg::EXIT_CYC; // R18
      state_nxt = ST_EXIT_WAIT;
    end
  end

  // Per-device addressing qualifies every mode write on data bit zero.
  always_comb begin
    dq0_nxt = 1'b0;
    dq0_oe_nxt = 1'b0;
    if (cmd_nxt == vref_train_pkg::CMD_MRS && pda_r) begin
      dq0_oe_nxt = 1'b1; // R15
      dq0_nxt = skip_r; // R15
    end
  end

  // Configuration and the sticky refusal flag; a new refusal wins.
  always_comb begin
    pda_nxt = pda_r;
    skip_nxt = skip_r;
    err_nxt = err_r;
    if (wr_cfg) begin
      pda_nxt = WDATA_I[vref_train_pkg::CFG_PDA_BIT];
      skip_nxt = WDATA_I[vref_train_pkg::CFG_SKIP_BIT];
    end
    if (wr_status && WDATA_I[vref_train_pkg::ST_ERROR_BIT]) begin
      err_nxt = 1'b0;
    end
    if (refused) begin
      err_nxt = 1'b1;
    end
  end

  // Read data stand in the cycle after the read strobe.
  always_comb begin
    rdata_nxt = vref_train_pkg::RDATA_NONE;
    if (RD_I) begin
      case (ADDR_I)
        vref_train_pkg::OFS_CTRL: begin
          rdata_nxt[vref_train_pkg::CTRL_RANGE_BIT] = range_r;
          rdata_nxt[vref_train_pkg::CTRL_CODE_LSB +: CW] = code_r;
        end
        vref_train_pkg::OFS_CFG: begin
          rdata_nxt[vref_train_pkg::CFG_PDA_BIT] = pda_r;
          rdata_nxt[vref_train_pkg::CFG_SKIP_BIT] = skip_r;
        end
        vref_train_pkg::OFS_STATUS: begin
          rdata_nxt[vref_train_pkg::ST_ACTIVE_BIT] = (state_r != ST_IDLE);
          rdata_nxt[vref_train_pkg::ST_BUSY_BIT] =
            (state_r != ST_IDLE) && (state_r != ST_ACTIVE);
          rdata_nxt[vref_train_pkg::ST_LEVEL_OK_BIT] = level_ok_r; // R1
          rdata_nxt[vref_train_pkg::ST_ERROR_BIT] = err_r;
          rdata_nxt[vref_train_pkg::ST_RANGE_BIT] = range_r;
          rdata_nxt[vref_train_pkg::ST_CODE_LSB +: CW] = code_r;
        end
        default: begin
          rdata_nxt = vref_train_pkg::RDATA_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      state_r <= ST_IDLE;
      range_r <= 1'b0;
      code_r <= vref_train_pkg::CODE_ZERO;
      level_ok_r <= 1'b0;
      first_level_r <= 1'b1;
      err_r <= 1'b0;
      pda_r <= 1'b0;
      skip_r <= 1'b0;
      cmd_r <= vref_train_pkg::CMD_DES;
      mr_r <= 8'h00;
      dq0_r <= 1'b0;
      dq0_oe_r <= 1'b0;
      rdata_r <= vref_train_pkg::RDATA_NONE;
    end else begin
      state_r <= state_nxt;
      range_r <= range_nxt;
      code_r <= code_nxt;
      level_ok_r <= level_ok_nxt;
      first_level_r <= first_level_nxt;
      err_r <= err_nxt;
      pda_r <= pda_nxt;
      skip_r <= skip_nxt;
      cmd_r <= cmd_nxt;
      mr_r <= mr_nxt;
      dq0_r <= dq0_nxt;
      dq0_oe_r <= dq0_oe_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign CMD_O = cmd_r;
  assign MR_ADDR_O = mr_r;
  assign DQ0_O = dq0_r;
  assign DQ0_OE_O = dq0_oe_r;
  assign RDATA_O = rdata_r;
endmodule
`default_nettype wire

// *** rtl/wait_timer.sv ***
/*
 Down counter for protocol waits: busy from the edge after a load until
 count cycles have passed. Assumes a synchronous active-high reset.
*/
`default_nettype none
module wait_timer #(parameter int W = 8) (
  input wire logic clk_i,   // Controller clock.
  input wire logic rst_i,   // Synchronous reset, active high.
  timer_if.timer tmr        // Load and busy.
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (tmr.load) begin
      cnt_nxt = tmr.count;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tmr.busy = (cnt_r != '0);
endmodule
`default_nettype wire

// *** verif/test_vref_train_ctrl.sv ***
/*
 Self-checking bench for the training controller.
 Assumes the device model and the checker are compiled first.
*/
`default_nettype none
module test_vref_train_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, wr, rd, init, idle, dq0, oe, per_device_addressing, rng, m_on, m_rng;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, s, seed;
  logic [2:0] cmd;
  logic [7:0] mr;
  logic [5:0] m_code, code;
  int bad_count, num_checks, cycles;
  vref_train_ctrl u_vref_train_ctrl (.MCLK_I(clk), .RESET_I(rst),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .INIT_DONE_I(init), .BANKS_IDLE_I(idle), .CMD_O(cmd),
    .MR_ADDR_O(mr), .DQ0_O(dq0), .DQ0_OE_O(oe));
  // The data line is terminated high when nobody drives it.
  vref_device_model u_vref_device_model (.clk_i(clk), .rst_i(rst),
    .cmd_i(cmd), .addr_i(mr), .dq0_i(oe ? dq0 : 1'b1), .pda_i(per_device_addressing),
    .active_o(m_on), .range_o(m_rng), .code_o(m_code));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      bad_count++;
      results();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] ctl(input logic [1:0] op,
      input logic r, input logic [5:0] c);
    return {18'h0_0000, c, 5'h00, r, op};
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    s = rdata;
  endtask
  // Polls one status bit until it clears.
  task automatic wait_clear(input int b);
    s = 32'hFFFF_FFFF;
    for (int i = 0; i < 40 && s[b] !== 1'b0; i++) rreg(4'hC);
    chk("status bit", 32'(s[b]), 32'h0);
  endtask
  task automatic refused();
    chk("no command", 32'(cmd), 32'h0);
    rreg(4'hC);
    chk("error flag", 32'(s[3]), 32'h1);
    wreg(4'hC, 32'h0000_0008);
  endtask
  task automatic level(input logic [5:0] c, input logic [1:0] dq,
      input logic [5:0] dev);
    wreg(4'h0, ctl(2'h2, ~rng, c));
    chk("level bits", 32'({cmd, mr}), 32'({3'h7, 1'b1, rng, c}));
    chk("data bit", 32'({oe, dq0}), 32'(dq));
    wait_clear(1);
    chk("device code", 32'(m_code), 32'(dev));
  endtask
  initial begin
    {rst, wr, rd, init, idle, per_device_addressing} = 6'h22;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    seed = 32'h6264_fbd8;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rreg(4'hC);
    chk("status", 32'(s[3:0]), 32'h0);
    rreg(4'h2);
    chk("unmapped", s, 32'h0);
    wreg(4'h0, ctl(2'h1, 1'b0, 6'h00));
    refused();
    $display("test reset done");
    @(posedge clk);
    init <= 1'b1;
    repeat (3) @(posedge clk);
    seed = lfsr(seed);
    rng = seed[0];
    wreg(4'h0, ctl(2'h1, rng, seed[13:8]));
    chk("entry bits", 32'({cmd, mr}), 32'({3'h7, 1'b1, rng, 6'h00}));
    wreg(4'h8, 32'h2);
    refused();
    wait_clear(1);
    chk("device mode", 32'({m_on, m_rng}), 32'({1'b1, rng}));
    for (int c = 1; c < 7; c++) begin
      wreg(4'h8, 32'(c));
      chk("user cmd", 32'(cmd), 32'(c));
    end
    wreg(4'h8, 32'h7);
    refused();
    $display("test entry done");
    level(6'h10, 2'h0, 6'h10);
    level(6'h11, 2'h0, 6'h11);
    level(6'h00, 2'h0, 6'h00);
    level(6'h32, 2'h0, 6'h32);
    repeat (4) begin
      seed = lfsr(seed);
      code = 6'(seed % 32'd51);
      level(code, 2'h0, code);
    end
    wreg(4'h0, ctl(2'h2, rng, 6'h33));
    refused();
    $display("test levels done");
    per_device_addressing = 1'b1;
    wreg(4'h4, 32'h3);
    level(6'h21, 2'h3, code);
    wreg(4'h8, 32'h4);
    refused();
    wreg(4'h4, 32'h1);
    level(6'h22, 2'h2, 6'h22);
    wreg(4'h4, 32'h0);
    per_device_addressing = 1'b0;
    $display("test per-device done");
    @(posedge clk);
    idle <= 1'b0;
    // Let the busy level pass both synchroniser stages first.
    repeat (2) @(posedge clk);
    wreg(4'h0, ctl(2'h3, ~rng, 6'h05));
    repeat (8) @(posedge clk);
    idle <= 1'b1;
    #1;
    chk("exit held", 32'(cmd), 32'h0);
    for (int i = 0; i < 20 && cmd !== 3'h7; i++) #10;
    chk("exit bits", 32'({cmd, mr}), 32'({3'h7, 1'b0, rng, 6'h22}));
    wait_clear(0);
    chk("device exit", 32'({m_on, m_rng, m_code}), 32'({1'b0, rng, 6'h22}));
    wreg(4'h0, ctl(2'h2, rng, 6'h01));
    refused();
    $display("test exit done");
    results();
  end
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
endmodule
bind vref_train_ctrl vref_train_ctrl_properties u_vref_train_ctrl_properties (
  .MCLK_I, .RESET_I, .ADDR_I, .WDATA_I, .WR_I, .INIT_DONE_I, .BANKS_IDLE_I,
  .CMD_O, .MR_ADDR_O, .DQ0_OE_O);
`default_nettype wire

// *** verif/vref_device_model.sv ***
/*
 Behavioural memory device: the training mode register only.
 Assumes commands arrive on the controller clock.
*/
`default_nettype none
module vref_device_model (
  input wire logic clk_i,        // Clock.
  input wire logic rst_i,        // Power-up.
  input wire logic [2:0] cmd_i,  // Command.
  input wire logic [7:0] addr_i, // Mode bits.
  input wire logic dq0_i,        // Resolved data bit zero.
  input wire logic pda_i,        // Per-device addressing.
  output logic active_o,         // Training active.
  output logic range_o,          // Stored range.
  output logic [5:0] code_o      // Stored level.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic take;
  assign take = cmd_i == 3'h7 && (!pda_i || !dq0_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_o <= 1'b0;
      range_o <= 1'b0;
      code_o <= 6'h00;
    end else if (take && addr_i[7]) begin
      active_o <= 1'b1;
      range_o <= addr_i[6];
      code_o <= active_o ? addr_i[5:0] : code_o;
    end else if (take) begin
      active_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** verif/vref_train_ctrl_properties.sv ***
/*
 Checker for the training controller's command pins.
 Assumes it is bound to the controller's top module.
*/
`default_nettype none
module vref_train_ctrl_properties (
  input wire logic MCLK_I,          // Clock.
  input wire logic RESET_I,         // Reset.
  input wire logic [3:0] ADDR_I,    // Address.
  input wire logic [31:0] WDATA_I,  // Write data.
  input wire logic WR_I,            // Write strobe.
  input wire logic INIT_DONE_I,     // Initialised.
  input wire logic BANKS_IDLE_I,    // Banks idle.
  input wire logic [2:0] CMD_O,     // Command.
  input wire logic [7:0] MR_ADDR_O, // Mode bits.
  input wire logic DQ0_OE_O         // Data bit drive.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic in_r, rng_r, pda_r, mrs, on;
  logic [5:0] code_r;
  assign mrs = CMD_O == 3'h7;
  assign on = MR_ADDR_O[7];
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  // Shadow of the training state as seen on the pins.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      in_r <= 1'b0;
      rng_r <= 1'b0;
      code_r <= 6'h00;
      pda_r <= 1'b0;
    end else begin
      if (mrs) begin
        in_r <= on;
        rng_r <= in_r ? rng_r : MR_ADDR_O[6];
        code_r <= (in_r && on) ? MR_ADDR_O[5:0] : code_r;
      end
      if (WR_I && ADDR_I == 4'h4) begin
        pda_r <= WDATA_I[0];
      end
    end
  end
  property p_entry;
    mrs && on && !in_r |=> (CMD_O == 3'h0)[*8] ##1 (CMD_O == 3'h0)[*7];
  endproperty
  a_entry: assert property (p_entry) else $error("entry wait");
  property p_settle; mrs && on && in_r |=> (CMD_O == 3'h0)[*6]; endproperty
  a_settle: assert property (p_settle) else $error("settle wait");
  property p_exit;
    mrs && !on |=> (CMD_O == 3'h0)[*8] ##1 (CMD_O == 3'h0)[*7];
  endproperty
  a_exit: assert property (p_exit) else $error("exit wait");
  property p_dq0; DQ0_OE_O == (mrs && pda_r); endproperty
  a_dq0: assert property (p_dq0) else $error("data bit drive");
  property p_keep;
    mrs && !on |-> in_r && MR_ADDR_O[6:0] == {rng_r, code_r};
  endproperty
  a_keep: assert property (p_keep) else $error("exit bits");
  property p_init; mrs && !in_r |-> $past(INIT_DONE_I, 3); endproperty
  a_init: assert property (p_init) else $error("entry early");
  property p_pda; pda_r |-> CMD_O == 3'h0 || mrs; endproperty
  a_pda: assert property (p_pda) else $error("command in pda");
  property p_idle; !in_r |-> CMD_O == 3'h0 || mrs; endproperty
  a_idle: assert property (p_idle) else $error("command idle");
  property p_banks; mrs && !on |-> $past(BANKS_IDLE_I, 3); endproperty
  a_banks: assert property (p_banks) else $error("exit busy");
endmodule
`default_nettype wire
